/* File: verilog/ptai_trip_action.sv */
// Trip response: output actions, interrupt enables, sticky status and register slave
`timescale 1ns/10ps
`default_nettype none
`include "ptai_defs.svh"

// Functional notes
// - DC A event 1 field 5-4 acts on A
// - Trip zone field 3-2 acts on B
// - Trip zone field 1-0 acts on A
// - Only selected trip pins cause trip events
// - Enable bit 6 gates DC B event 2
// - Enable bit 5 gates DC B event 1
// - Enable bit 4 gates DC A event 2
// - Enable bit 3 gates DC A event 1
// - Enable bit 2 gates one-shot trip interrupt
// - Enable bit 1 gates cycle-by-cycle interrupt
// - DC B event 2 field 11-10 acts on B
// - DC B event 1 field 9-8 acts on B
// - DC A event 2 field 7-6 acts on A
module ptai_trip_action
  import ptai_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Avalon-MM slave
  input wire logic [`PTAI_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [1:0] avs_response,
  // Trip events, already qualified by the source select unit
  input wire logic one_shot_trip,
  input wire logic per_cycle_trip,
  input wire logic dcmp_a_event_one,
  input wire logic dcmp_a_event_two,
  input wire logic dcmp_b_event_one,
  input wire logic dcmp_b_event_two,
  // Waveform from the PWM datapath
  input wire logic pwm_in_a,
  input wire logic pwm_in_b,
  // Pins to the power stage
  output logic pwm_output_a,
  output logic pwm_output_a_oe,
  output logic pwm_output_b,
  output logic pwm_output_b_oe,
  // Interrupt
  output logic trip_interrupt_request
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    ptai_bus_state_type bus;
    logic [15:0] ctl;
    logic [15:0] en;
    logic [15:0] stat;
    logic [15:0] mask;
    logic [31:0] rdata;
    logic [1:0] resp;
    ptai_pin_type pin_a;
    ptai_pin_type pin_b;
    logic irq;
    logic wait_req;
  } ptai_state_type;

  ptai_state_type state_q;
  ptai_state_type state_d;
  ptai_events_type evt;
  ptai_pin_type res_a;
  ptai_pin_type res_b;
  logic [15:0] evt_vec;
  logic [15:0] wmask;
  logic trip_any;
  logic addr_ok;

  always_comb begin
    evt.one_shot_trip = one_shot_trip;
    evt.per_cycle_trip = per_cycle_trip;
    evt.dcmp_a_event_one = dcmp_a_event_one;
    evt.dcmp_a_event_two = dcmp_a_event_two;
    evt.dcmp_b_event_one = dcmp_b_event_one;
    evt.dcmp_b_event_two = dcmp_b_event_two;
  end

  // Trip inputs arrive already filtered by the source selection, so any one counts
  assign trip_any = evt.one_shot_trip | evt.per_cycle_trip;

  // ----------------------------------------------------------------
  // Output actions
  // ----------------------------------------------------------------
  ptai_out_action u_act_a (
    .trip_event(trip_any),
    .dc_event_one(evt.dcmp_a_event_one),
    .dc_event_two(evt.dcmp_a_event_two),
    .trip_code(state_q.ctl[`PTAI_TZA_LSB +: 2]),
    .dc_one_code(state_q.ctl[`PTAI_DCA1_LSB +: 2]),
    .dc_two_code(state_q.ctl[`PTAI_DCA2_LSB +: 2]),
    .pwm_in(pwm_in_a),
    .pin(res_a)
  );

  ptai_out_action u_act_b (
    .trip_event(trip_any),
    .dc_event_one(evt.dcmp_b_event_one),
    .dc_event_two(evt.dcmp_b_event_two),
    .trip_code(state_q.ctl[`PTAI_TZB_LSB +: 2]),
    .dc_one_code(state_q.ctl[`PTAI_DCB1_LSB +: 2]),
    .dc_two_code(state_q.ctl[`PTAI_DCB2_LSB +: 2]),
    .pwm_in(pwm_in_b),
    .pin(res_b)
  );

  // ----------------------------------------------------------------
  // Event vector in enable-register layout
  // ----------------------------------------------------------------
  always_comb begin
    evt_vec = 16'h0000;
    evt_vec[`PTAI_BIT_CBC] = evt.per_cycle_trip & state_q.en[`PTAI_BIT_CBC];
    evt_vec[`PTAI_BIT_OST] = evt.one_shot_trip & state_q.en[`PTAI_BIT_OST];
    evt_vec[`PTAI_BIT_DCA1] = evt.dcmp_a_event_one & state_q.en[`PTAI_BIT_DCA1];
    evt_vec[`PTAI_BIT_DCA2] = evt.dcmp_a_event_two & state_q.en[`PTAI_BIT_DCA2];
    evt_vec[`PTAI_BIT_DCB1] = evt.dcmp_b_event_one & state_q.en[`PTAI_BIT_DCB1];
    evt_vec[`PTAI_BIT_DCB2] = evt.dcmp_b_event_two & state_q.en[`PTAI_BIT_DCB2];
  end

  assign wmask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  assign addr_ok = (avs_address == `PTAI_OFF_ACTION_CTL) ||
                   (avs_address == `PTAI_OFF_INT_ENABLE) ||
                   (avs_address == `PTAI_OFF_INT_STATUS) ||
                   (avs_address == `PTAI_OFF_INT_MASK);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    state_d.pin_a = res_a;
    state_d.pin_b = res_b;
    // Sticky status; set wins over a same-cycle clear
    state_d.stat = state_q.stat | evt_vec;
    unique case (state_q.bus)
      PTAI_BUS_IDLE: begin
        // Two wait cycles let the answer come from registers only
        if (avs_read || avs_write) begin
          state_d.bus = PTAI_BUS_WAIT;
        end
      end
      PTAI_BUS_WAIT: begin
        state_d.bus = PTAI_BUS_DONE;
        state_d.resp = addr_ok ? 2'h0 : 2'h2;
        state_d.rdata = 32'h0000_0000;
        if (avs_read && addr_ok) begin
          unique case (avs_address)
            `PTAI_OFF_ACTION_CTL: state_d.rdata[15:0] = state_q.ctl;
            `PTAI_OFF_INT_ENABLE: state_d.rdata[15:0] = state_q.en;
            `PTAI_OFF_INT_STATUS: state_d.rdata[15:0] = state_q.stat;
            default: state_d.rdata[15:0] = state_q.mask;
          endcase
        end
        if (avs_write && addr_ok) begin
          unique case (avs_address)
            `PTAI_OFF_ACTION_CTL: begin
              state_d.ctl = ((state_q.ctl & ~wmask) | (avs_writedata[15:0] & wmask))
                            & `PTAI_CTL_MASK;
            end
            `PTAI_OFF_INT_ENABLE: begin
              state_d.en = ((state_q.en & ~wmask) | (avs_writedata[15:0] & wmask))
                           & `PTAI_EVT_MASK;
            end
            `PTAI_OFF_INT_STATUS: begin
              state_d.stat = (state_q.stat & ~(avs_writedata[15:0] & wmask)) | evt_vec;
            end
            default: begin
              state_d.mask = ((state_q.mask & ~wmask) | (avs_writedata[15:0] & wmask))
                             & `PTAI_EVT_MASK;
            end
          endcase
        end
      end
      PTAI_BUS_DONE: begin
        state_d.bus = PTAI_BUS_IDLE;
      end
    endcase
    state_d.irq = |(state_d.stat & state_d.mask);
    // Registered so the bus sees waitrequest straight from a flop
    state_d.wait_req = (state_d.bus != PTAI_BUS_DONE);
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      state_q.bus <= PTAI_BUS_IDLE;
      state_q.ctl <= `PTAI_RST_CTL;
      state_q.en <= `PTAI_RST_EN;
      state_q.stat <= `PTAI_RST_STAT;
      state_q.mask <= `PTAI_RST_MASK;
      state_q.rdata <= 32'h0000_0000;
      state_q.resp <= 2'h0;
      state_q.pin_a <= '0;
      state_q.pin_b <= '0;
      state_q.irq <= 1'b0;
      state_q.wait_req <= 1'b1;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign avs_readdata = state_q.rdata;
  assign avs_response = state_q.resp;
  assign avs_waitrequest = state_q.wait_req;
  assign pwm_output_a = state_q.pin_a.level;
  assign pwm_output_a_oe = state_q.pin_a.oe;
  assign pwm_output_b = state_q.pin_b.level;
  assign pwm_output_b_oe = state_q.pin_b.oe;
  assign trip_interrupt_request = state_q.irq;

endmodule

`default_nettype wire

/* File: verilog/ptai_defs.svh */
// Register offsets, field positions, reset values and codes for the trip action block
`ifndef PTAI_DEFS_SVH
`define PTAI_DEFS_SVH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define PTAI_ADDR_W 4
`define PTAI_OFF_ACTION_CTL 4'h0
`define PTAI_OFF_INT_ENABLE 4'h4
`define PTAI_OFF_INT_STATUS 4'h8
`define PTAI_OFF_INT_MASK 4'hC

// ----------------------------------------------------------------
// Field positions (low bit of each 2-bit action field)
// ----------------------------------------------------------------
`define PTAI_TZA_LSB 0
`define PTAI_TZB_LSB 2
`define PTAI_DCA1_LSB 4
`define PTAI_DCA2_LSB 6
`define PTAI_DCB1_LSB 8
`define PTAI_DCB2_LSB 10
`define PTAI_CTL_MASK 16'h0FFF
`define PTAI_EVT_MASK 16'h007E

// ----------------------------------------------------------------
// Event bit positions in enable, status and mask registers
// ----------------------------------------------------------------
`define PTAI_BIT_CBC 1
`define PTAI_BIT_OST 2
`define PTAI_BIT_DCA1 3
`define PTAI_BIT_DCA2 4
`define PTAI_BIT_DCB1 5
`define PTAI_BIT_DCB2 6

// ----------------------------------------------------------------
// Reset values and action codes
// ----------------------------------------------------------------
`define PTAI_RST_CTL 16'h0000
`define PTAI_RST_EN 16'h0000
`define PTAI_RST_STAT 16'h0000
`define PTAI_RST_MASK 16'h0000
`define PTAI_ACT_HIZ 2'h0
`define PTAI_ACT_HIGH 2'h1
`define PTAI_ACT_LOW 2'h2
`define PTAI_ACT_NONE 2'h3

`endif

/* File: verilog/ptai_pkg.sv */
// Types shared by the trip action block
package ptai_pkg;

  typedef struct packed {
    logic one_shot_trip;
    logic per_cycle_trip;
    logic dcmp_a_event_one;
    logic dcmp_a_event_two;
    logic dcmp_b_event_one;
    logic dcmp_b_event_two;
  } ptai_events_type;

  typedef struct packed {
    logic level;
    logic oe;
  } ptai_pin_type;

  typedef enum logic [2:0] {
    PTAI_BUS_IDLE = 3'b001,
    PTAI_BUS_WAIT = 3'b010,
    PTAI_BUS_DONE = 3'b100
  } ptai_bus_state_type;

endpackage

/* File: verilog/ptai_out_action.sv */
// One output's trip action resolver
`timescale 1ns/10ps
`default_nettype none

module ptai_out_action
  import ptai_pkg::*;
(
  // Events steering this output
  input wire logic trip_event,
  input wire logic dc_event_one,
  input wire logic dc_event_two,
  // Action codes
  input wire logic [1:0] trip_code,
  input wire logic [1:0] dc_one_code,
  input wire logic [1:0] dc_two_code,
  // Normal waveform
  input wire logic pwm_in,
  // Resolved pin
  output ptai_pin_type pin
);
`include "ptai_defs.svh"

  logic [1:0] code;

  // Trip zone wins over compare events; code 11 passes the waveform
  always_comb begin
    code = `PTAI_ACT_NONE;
    if (dc_event_two && dc_two_code != `PTAI_ACT_NONE) begin
      code = dc_two_code;
    end
    if (dc_event_one && dc_one_code != `PTAI_ACT_NONE) begin
      code = dc_one_code;
    end
    if (trip_event && trip_code != `PTAI_ACT_NONE) begin
      code = trip_code;
    end
    pin.oe = 1'b1;
    pin.level = pwm_in;
    unique case (code)
      `PTAI_ACT_HIZ: begin
        pin.oe = 1'b0;
        pin.level = 1'b0;
      end
      `PTAI_ACT_HIGH: pin.level = 1'b1;
      `PTAI_ACT_LOW: pin.level = 1'b0;
      `PTAI_ACT_NONE: pin.level = pwm_in;
    endcase
  end

endmodule

`default_nettype wire

/* File: tb/ptai_trip_action_monitor.sv */
// Port-level checker for the trip action block
`timescale 1ns/10ps
`default_nettype none
module ptai_trip_action_monitor
  import ptai_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Bus
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [1:0] avs_response,
  // Events
  input wire logic one_shot_trip,
  input wire logic per_cycle_trip,
  input wire logic dcmp_a_event_one,
  input wire logic dcmp_a_event_two,
  input wire logic dcmp_b_event_one,
  input wire logic dcmp_b_event_two,
  // Pins and interrupt
  input wire logic pwm_in_a,
  input wire logic pwm_in_b,
  input wire logic pwm_output_a,
  input wire logic pwm_output_a_oe,
  input wire logic pwm_output_b,
  input wire logic pwm_output_b_oe,
  input wire logic trip_interrupt_request
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  wire trip = one_shot_trip | per_cycle_trip;
  wire hit_a = trip | dcmp_a_event_one | dcmp_a_event_two;
  wire hit_b = trip | dcmp_b_event_one | dcmp_b_event_two;
  wire any_evt = hit_a | hit_b;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  wait_count_a: assert property ($rose(avs_read | avs_write) |->
    avs_waitrequest ##1 avs_waitrequest ##1 !avs_waitrequest) else $error("bad wait count");
  reserved_zero_a: assert property (!avs_waitrequest && avs_read |->
    avs_readdata[31:12] == 20'h00000) else $error("reserved bits set");
  reserved_evt_a: assert property (!avs_waitrequest && avs_read && avs_address != 4'h0
    |-> avs_readdata[15:7] == 9'h000 && !avs_readdata[0]) else $error("event reserved set");
  unmapped_a: assert property (!avs_waitrequest && avs_read && avs_address[1:0] != 2'h0
    |-> avs_response == 2'h2 && avs_readdata == 32'h0) else $error("unmapped not refused");
  irq_cause_a: assert property ($rose(trip_interrupt_request) |-> $past(any_evt) ||
    $past(avs_write) || $past(avs_write, 2)) else $error("irq without cause");
  a_follow_a: assert property (!hit_a |=> pwm_output_a_oe &&
    pwm_output_a == $past(pwm_in_a)) else $error("output a not following");
  b_follow_a: assert property (!hit_b |=> pwm_output_b_oe &&
    pwm_output_b == $past(pwm_in_b)) else $error("output b not following");
  a_hiz_cause_a: assert property (!pwm_output_a_oe |->
    $past(hit_a) || !$past(reset_n)) else $error("output a released without event");
endmodule
bind ptai_trip_action ptai_trip_action_monitor u_mon (.*);
`default_nettype wire

/* File: tb/ptai_gate_model.sv */
// Gate driver input model: a released pin floats away from its last level
`timescale 1ns/10ps
`default_nettype none
module ptai_gate_model
  import ptai_pkg::*;
(
  // Clock
  input wire logic core_clk,
  // Pins
  input wire logic pwm_output_a,
  input wire logic pwm_output_a_oe,
  input wire logic pwm_output_b,
  input wire logic pwm_output_b_oe,
  // Seen at the gates
  output logic gate_a,
  output logic gate_b
);
  logic [1:0] last_q;
  // Remember only driven levels, so a released pin shows a steady inverse
  always_ff @(posedge core_clk) begin
    if (pwm_output_a_oe) begin
      last_q[0] <= pwm_output_a;
    end
    if (pwm_output_b_oe) begin
      last_q[1] <= pwm_output_b;
    end
  end
  assign gate_a = pwm_output_a_oe ? pwm_output_a : ~last_q[0];
  assign gate_b = pwm_output_b_oe ? pwm_output_b : ~last_q[1];
endmodule
`default_nettype wire

/* File: tb/ptai_trip_action_bench.sv */
// Self-checking bench for the trip action block
`timescale 1ns/10ps
`default_nettype none
module ptai_trip_action_bench import ptai_pkg::*;;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata, q;
  logic [1:0] avs_response, rsp, pin;
  logic avs_waitrequest, trip_interrupt_request, gate_a, gate_b;
  logic pwm_output_a, pwm_output_a_oe, pwm_output_b, pwm_output_b_oe;
  logic pwm_in_a = 1'b0;
  logic pwm_in_b = 1'b0;
  logic [6:0] evb = 7'h00;
  int errors = 0;
  int checks = 0;
  int lsb_t[6] = '{0, 4, 6, 2, 8, 10};
  int bit_t[6] = '{2, 3, 4, 1, 5, 6};
  logic [1:0] act_t[4] = '{2'h0, 2'h3, 2'h2, 2'h3};
  ptai_trip_action u_dut (.*, .one_shot_trip(evb[2]), .per_cycle_trip(evb[1]),
    .dcmp_a_event_one(evb[3]), .dcmp_a_event_two(evb[4]),
    .dcmp_b_event_one(evb[5]), .dcmp_b_event_two(evb[6]));
  ptai_gate_model u_gate (.*);
  initial forever #20 core_clk = ~core_clk;
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic [3:0] a, input logic w, input logic [15:0] d);
    @(posedge core_clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {16'h0000, d};
    do begin
      @(posedge core_clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    rsp = avs_response;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic fire(input logic [6:0] e);
    @(posedge core_clk) evb <= e;
    @(posedge core_clk) evb <= 7'h00;
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(posedge core_clk);
    reset_n <= 1'b1;
    // An unmapped write must leave every register at its reset value
    bus(4'h2, 1'b1, 16'hFFFF);
    for (int i = 0; i < 16; i += 4) begin
      bus(4'(i), 1'b0, 16'h0);
      chk(q, 32'h0);
      chk({30'h0, rsp}, 32'h0);
    end
    bus(4'h0, 1'b1, 16'hFFFF);
    bus(4'h0, 1'b0, 16'h0);
    chk(q, 32'h0FFF);
    bus(4'h4, 1'b1, 16'hFFFF);
    bus(4'h4, 1'b0, 16'h0);
    chk(q, 32'h007E);
    bus(4'h2, 1'b0, 16'h0);
    chk({q[31:2], rsp}, 32'h2);
    $display("test registers done");
    for (int s = 0; s < 6; s++) begin
      for (int c = 0; c < 4; c++) begin
        bus(4'h0, 1'b1, (16'h0FFF & ~(16'h3 << lsb_t[s])) | (16'(c) << lsb_t[s]));
        @(posedge core_clk);
        evb <= 7'h01 << bit_t[s];
        pwm_in_a <= (c != 1);
        pwm_in_b <= (c != 1);
        repeat (2) @(posedge core_clk);
        #1;
        pin = (s < 3) ? {pwm_output_a_oe, gate_a} : {pwm_output_b_oe, gate_b};
        chk({30'h0, pin & {2{pin[1]}}}, {30'h0, act_t[c]});
        @(posedge core_clk) evb <= 7'h00;
      end
    end
    $display("test actions done");
    bus(4'h8, 1'b1, 16'h007E);
    for (int i = 1; i < 7; i++) begin
      fire(7'h01 << i);
      bus(4'h8, 1'b0, 16'h0);
      chk(q, 32'h1 << i);
      chk({31'h0, trip_interrupt_request}, 32'h0);
      bus(4'hC, 1'b1, 16'h1 << i);
      repeat (2) @(posedge core_clk);
      chk({31'h0, trip_interrupt_request}, 32'h1);
      bus(4'h8, 1'b1, 16'h1 << i);
      repeat (2) @(posedge core_clk);
      chk({31'h0, trip_interrupt_request}, 32'h0);
      bus(4'hC, 1'b1, 16'h0);
    end
    bus(4'h4, 1'b1, 16'h0);
    fire(7'h7E);
    bus(4'h8, 1'b0, 16'h0);
    chk(q, 32'h0);
    $display("test interrupts done");
    final_report;
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    errors++;
    $display("ERROR %0t: watchdog expired", $time);
    final_report;
  end
endmodule
`default_nettype wire
